// ### late_collision_pkg.sv
// constants for the late collision counters and their register map
// assumes a single 50 MHz clock and a synchronous active-high reset
// Contract
// - late means after first 512 bit times
// - four 8-bit counters, paired in two registers
// - count only half-duplex copper operation
// - window of collision start picks one counter
// - read returns value then clears counter
// - counters saturate at ff, never wrap
// - early low byte counts bytes 65-96
// - early high byte counts bytes 97-128
// - late low byte counts bytes 129-192
// - late high byte counts beyond 192
// - byte positions measured on internal gmii
// - five-bit advance field at bits 12:8
// - advance shifts every window earlier
package late_collision_pkg;

   localparam int addr_width = 5;
   localparam int data_width = 32;
   localparam int count_width = 8;
   localparam int pos_width = 9;
   localparam int adjust_width = 5;
   localparam int window_count = 4;

   // byte addresses, one aligned word each
   localparam logic [4:0] count_early_offset = 5'h00;
   localparam logic [4:0] count_late_offset = 5'h04;
   localparam logic [4:0] window_adjust_offset = 5'h08;
   localparam logic [4:0] irq_status_offset = 5'h0c;
   localparam logic [4:0] irq_mask_offset = 5'h10;

   localparam int adjust_lsb = 8;
   localparam int adjust_msb = 12;
   localparam int adjust_lane = 1;

   localparam logic [7:0] count_reset = 8'h00;
   localparam logic [7:0] count_max = 8'hff;
   localparam logic [4:0] adjust_reset = 5'h00;
   localparam logic [3:0] irq_reset = 4'h0;
   localparam logic [8:0] pos_max = 9'h1ff;

   // first byte of each window with zero advance; 64 bytes = 512 bit times
   localparam logic [8:0] window1_first = 9'h041;
   localparam logic [8:0] window2_first = 9'h061;
   localparam logic [8:0] window3_first = 9'h081;
   localparam logic [8:0] window4_first = 9'h0c1;

   typedef enum logic [1:0] {
      bus_idle = 2'b01,
      bus_ack = 2'b10
   } bus_state_type;

endpackage

// ### tx_byte_tracker.sv
// counts transmitted bytes of the current frame on the internal gmii
// assumes one byte per clock while tx_en is high
`timescale 1ns/1ns
module tx_byte_tracker (
   input wire logic clk,
   input wire logic reset,
   input wire logic tx_en,
   output logic [late_collision_pkg::pos_width-1:0] byte_index
);

   logic [late_collision_pkg::pos_width-1:0] sent_q;
   logic [late_collision_pkg::pos_width-1:0] sent_d;

   // index of the byte on the bus now, one-based
   always_comb begin
      if (sent_q == late_collision_pkg::pos_max) begin
         byte_index = sent_q;
      end else begin
         byte_index = sent_q + late_collision_pkg::pos_width'(1);
      end
   end

   // positions taken on the mac-facing byte stream
   always_comb begin
      if (!tx_en) begin
         sent_d = '0;
      end else begin
         sent_d = byte_index;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         sent_q <= '0;
      end else begin
         sent_q <= sent_d;
      end
   end

endmodule

// ### sat_clear_counter.sv
// one saturating 8-bit event counter with clear on read
// assumes inc and clr are single-cycle pulses in the clk domain
`timescale 1ns/1ns
module sat_clear_counter (
   input wire logic clk,
   input wire logic reset,
   input wire logic inc,
   input wire logic clr,
   output logic [late_collision_pkg::count_width-1:0] count
);

   logic [late_collision_pkg::count_width-1:0] count_q;
   logic [late_collision_pkg::count_width-1:0] count_d;

   always_comb begin
      count_d = count_q;
      if (clr) begin
         // event in the read cycle is kept, not lost
         count_d = inc ? 8'h01 : late_collision_pkg::count_reset;
      end else if (inc && count_q != late_collision_pkg::count_max) begin
         count_d = count_q + 8'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         count_q <= late_collision_pkg::count_reset;
      end else begin
         count_q <= count_d;
      end
   end

   assign count = count_q;

endmodule

// ### late_collision_counters.sv
// late collision counters with avalon-mm register slave and interrupt
// assumes gmii inputs already synchronous to clk, one byte per clock
`timescale 1ns/1ns
module late_collision_counters (
   input wire logic clk,
   input wire logic reset,
   input wire logic gmii_tx_en,
   input wire logic gmii_rx_dv,
   input wire logic half_duplex,
   input wire logic copper_active,
   input wire logic [late_collision_pkg::addr_width-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [late_collision_pkg::data_width-1:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [late_collision_pkg::data_width-1:0] readdata,
   output logic waitrequest,
   output logic irq
);

   localparam int wc = late_collision_pkg::window_count;

   logic [late_collision_pkg::pos_width-1:0] byte_index;
   logic rx_dv_q;
   logic rx_dv_d;
   logic rx_start;
   logic counting;
   logic [wc-1:0] hit;
   logic [wc-1:0] clr;
   logic [late_collision_pkg::count_width-1:0] count [wc];
   logic [late_collision_pkg::pos_width-1:0] first [wc];
   logic [late_collision_pkg::pos_width-1:0] adv;

   // register slave state
   late_collision_pkg::bus_state_type state_q;
   late_collision_pkg::bus_state_type state_d;
   logic waitrequest_q;
   logic waitrequest_d;
   logic [late_collision_pkg::data_width-1:0] readdata_q;
   logic [late_collision_pkg::data_width-1:0] readdata_d;
   logic [late_collision_pkg::data_width-1:0] read_word;
   logic accept;
   logic commit;

   // software-visible control and event state
   logic [late_collision_pkg::adjust_width-1:0] adjust_q;
   logic [late_collision_pkg::adjust_width-1:0] adjust_d;
   logic [wc-1:0] status_q;
   logic [wc-1:0] status_d;
   logic [wc-1:0] mask_q;
   logic [wc-1:0] mask_d;
   logic irq_q;
   logic irq_d;

   // byte position of the transmit stream

   tx_byte_tracker tracker (
      .clk(clk),
      .reset(reset),
      .tx_en(gmii_tx_en),
      .byte_index(byte_index)
   );

   // receive start detection

   // idle level of rx_dv is low, so no false edge after reset
   always_comb begin
      rx_dv_d = gmii_rx_dv;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         rx_dv_q <= 1'b0;
      end else begin
         rx_dv_q <= rx_dv_d;
      end
   end

   assign rx_start = gmii_rx_dv && !rx_dv_q;

   // only half-duplex copper traffic with a frame on tx
   assign counting = half_duplex && copper_active && gmii_tx_en;

   // window placement

   // advance is zero-extended to the position width
   assign adv = late_collision_pkg::pos_width'(adjust_q);

   // all windows move together by the same advance
   always_comb begin
      first[0] = late_collision_pkg::window1_first - adv;
      first[1] = late_collision_pkg::window2_first - adv;
      first[2] = late_collision_pkg::window3_first - adv;
      first[3] = late_collision_pkg::window4_first - adv;
   end

   // one window, one counter

   for (genvar k = 0; k < wc; k++) begin : window
      logic above_start;
      logic below_end;

      assign above_start = byte_index >= first[k];

      if (k == wc - 1) begin : open_end
         // last window has no upper bound
         assign below_end = 1'b1;
      end else begin : closed_end
         assign below_end = byte_index < first[k + 1];
      end

      // windows are disjoint, so the start picks at most one
      assign hit[k] = counting && rx_start && above_start && below_end;

      sat_clear_counter counter (
         .clk(clk),
         .reset(reset),
         .inc(hit[k]),
         .clr(clr[k]),
         .count(count[k])
      );
   end

   // avalon-mm slave handshake

   // a request is taken in idle and answered one cycle later
   assign accept = (state_q == late_collision_pkg::bus_idle) && (read || write);

   // writes land at the edge where waitrequest is seen low
   assign commit = (state_q == late_collision_pkg::bus_ack) && write;

   always_comb begin
      state_d = state_q;
      waitrequest_d = 1'b1;
      case (state_q)
         late_collision_pkg::bus_idle: begin
            if (read || write) begin
               state_d = late_collision_pkg::bus_ack;
               waitrequest_d = 1'b0;
            end
         end
         late_collision_pkg::bus_ack: begin
            state_d = late_collision_pkg::bus_idle;
         end
         default: begin
            state_d = late_collision_pkg::bus_idle;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_q <= late_collision_pkg::bus_idle;
         waitrequest_q <= 1'b1;
      end else begin
         state_q <= state_d;
         waitrequest_q <= waitrequest_d;
      end
   end

   // read decode

   always_comb begin
      read_word = '0;
      if (address == late_collision_pkg::count_early_offset) begin
         read_word = {16'h0000, count[1], count[0]};
      end else if (address == late_collision_pkg::count_late_offset) begin
         read_word = {16'h0000, count[3], count[2]};
      end else if (address == late_collision_pkg::window_adjust_offset) begin
         read_word = {19'h00000, adjust_q, 8'h00};
      end else if (address == late_collision_pkg::irq_status_offset) begin
         read_word = {28'h0000000, status_q};
      end else if (address == late_collision_pkg::irq_mask_offset) begin
         read_word = {28'h0000000, mask_q};
      end
   end

   // the word is captured when the read is taken and the pair clears then;
   // an event in that very cycle goes into the cleared counter
   always_comb begin
      clr = '0;
      if (accept && read) begin
         if (address == late_collision_pkg::count_early_offset) begin
            clr = 4'h3;
         end else if (address == late_collision_pkg::count_late_offset) begin
            clr = 4'hc;
         end
      end
   end

   always_comb begin
      readdata_d = readdata_q;
      if (accept && read) begin
         readdata_d = read_word;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         readdata_q <= '0;
      end else begin
         readdata_q <= readdata_d;
      end
   end

   // window advance register

   always_comb begin
      adjust_d = adjust_q;
      if (commit && address == late_collision_pkg::window_adjust_offset) begin
         if (byteenable[late_collision_pkg::adjust_lane]) begin
            adjust_d = writedata[late_collision_pkg::adjust_msb:late_collision_pkg::adjust_lsb];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         adjust_q <= late_collision_pkg::adjust_reset;
      end else begin
         adjust_q <= adjust_d;
      end
   end

   // interrupt mask

   always_comb begin
      mask_d = mask_q;
      if (commit && address == late_collision_pkg::irq_mask_offset) begin
         if (byteenable[0]) begin
            mask_d = writedata[wc-1:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         mask_q <= late_collision_pkg::irq_reset;
      end else begin
         mask_q <= mask_d;
      end
   end

   // interrupt status, one sticky bit per counter

   // write one to clear; a new event in the same cycle wins
   always_comb begin
      status_d = status_q;
      if (commit && address == late_collision_pkg::irq_status_offset) begin
         if (byteenable[0]) begin
            status_d = status_q & ~writedata[wc-1:0];
         end
      end
      status_d = status_d | hit;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         status_q <= late_collision_pkg::irq_reset;
      end else begin
         status_q <= status_d;
      end
   end

   // level interrupt, registered so the pin is glitch free
   always_comb begin
      irq_d = |(status_q & mask_q);
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= irq_d;
      end
   end

   // outputs straight from flops

   assign readdata = readdata_q;
   assign waitrequest = waitrequest_q;
   assign irq = irq_q;

endmodule

// ### late_collision_assertions.sv
// checker on the counter top ports
// bound to every late_collision_counters
`timescale 1ns/1ns
module late_collision_assertions (
   input wire logic clk,
   input wire logic reset,
   input wire logic gmii_tx_en,
   input wire logic half_duplex,
   input wire logic copper_active,
   input wire logic read,
   input wire logic write,
   input wire logic waitrequest,
   input wire logic irq);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // six quiet cycles cover any counting latency
   sequence calm(c); (!c && !write)[*6]; endsequence
   rst_irq_a: assert property (disable iff (1'b0) reset |=> !irq) else $error("irq in reset");
   rel_irq_a: assert property ($fell(reset) |-> !irq) else $error("irq at release");
   rd_wait_a: assert property (read |-> ##[0:8] !waitrequest) else $error("read hung");
   wr_wait_a: assert property (write |-> ##[0:8] !waitrequest) else $error("write hung");
   hd_gate_a: assert property (calm(half_duplex) |-> !$rose(irq)) else $error("full duplex count");
   cu_gate_a: assert property (calm(copper_active) |-> !$rose(irq)) else $error("fiber count");
   tx_gate_a: assert property (calm(gmii_tx_en) |-> !$rose(irq)) else $error("count without tx");
   irq_hold_a: assert property (!write[*3] ##0 irq |=> irq) else $error("irq dropped");
endmodule
bind late_collision_counters late_collision_assertions chk (.clk, .reset, .gmii_tx_en, .half_duplex,
   .copper_active, .read, .write, .waitrequest, .irq);

// ### mac_model.sv
// mac side: one frame of len bytes, collision from byte at
`timescale 1ns/1ns
module mac_model (
   input wire logic clk,
   input wire logic start,
   input wire logic [8:0] len,
   input wire logic [8:0] at,
   output logic tx_en,
   output logic rx_dv);
   logic [8:0] n = 9'h000;
   always @(posedge clk) n <= start ? 9'h001 : (n == len || n == 9'h000) ? 9'h000 : n + 9'h001;
   assign tx_en = n != 9'h000; // one byte a clock
   assign rx_dv = tx_en && n >= at && n < at + 9'h008;
endmodule

// ### late_collision_counters_bench.sv
// bench: mac model plus avalon master, 50 MHz clock
`timescale 1ns/1ns
module late_collision_counters_bench;
   logic clk = 1'b0, reset = 1'b1, read = 1'b0, write = 1'b0, hd = 1'b1, cu = 1'b1, go = 1'b0;
   logic [4:0] address = 5'h00;
   logic [31:0] writedata = 32'h0, readdata, rd;
   logic [8:0] at = 9'h000, len = 9'h000;
   logic tx_en, rx_dv, waitrequest, irq;
   int fails = 0, total_checks = 0, cyc = 0, a, b, i;
   int mid[5] = '{30, 80, 112, 160, 224};
   mac_model mac (.clk, .start(go), .len, .at, .tx_en, .rx_dv);
   late_collision_counters uut (.clk, .reset, .gmii_tx_en(tx_en), .gmii_rx_dv(rx_dv), .half_duplex(hd),
      .copper_active(cu), .address, .read, .write, .writedata, .byteenable(4'hf), .readdata, .waitrequest, .irq);
   initial forever #10 clk = ~clk;
   always @(posedge clk) if (++cyc == 60000) begin fails++; finish_test(); end
   task automatic bus(input logic w, input logic [4:0] ad, input logic [31:0] d);
      read <= !w;
      write <= w;
      address <= ad;
      writedata <= d;
      @(posedge clk);
      while (waitrequest !== 1'b0) @(posedge clk);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clk);
   endtask
   task automatic chk(input string n, input logic [15:0] x, input logic [15:0] y);
      total_checks++;
      if (x !== y) begin
         fails++;
         $display("mismatch %s exp %h got %h", n, y, x);
      end
   endtask
   // reads clear, so every look sees only the frames since the previous look
   task automatic look(input logic [31:0] e);
      bus(0, late_collision_pkg::count_early_offset, 0);
      chk("early", rd[15:0], e[15:0]);
      bus(0, late_collision_pkg::count_late_offset, 0);
      chk("late", rd[15:0], e[31:16]);
   endtask
   task automatic frame(input logic [8:0] l, input logic [8:0] x);
      len <= l;
      at <= x;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (l + 12) @(posedge clk);
   endtask
   function automatic logic [31:0] wexp(input int p);
      return p < 65 ? 0 : p < 97 ? 32'h1 : p < 129 ? 32'h100 : p < 193 ? 32'h10000 : 32'h1000000;
   endfunction
   task automatic finish_test();
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      a = $urandom(32'h25b924b5);
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      look(0);
      bus(1, late_collision_pkg::irq_mask_offset, 32'hf);
      for (i = 0; i < 17; i++) begin
         a = (i == 16) ? 0 : $urandom_range(10);
         hd <= i != 14;
         cu <= i != 15;
         bus(1, late_collision_pkg::window_adjust_offset, a << 8);
         bus(0, late_collision_pkg::window_adjust_offset, 0);
         chk("adjust", rd[12:8], a);
         b = mid[i % 5] + $urandom_range(14) - 7;
         frame(9'h104, b - a);
         look(i == 14 || i == 15 ? 0 : wexp(b));
      end
      repeat (257) frame(9'h05a, 9'h050);
      look(32'hff);
      look(0);
      chk("irq", {15'h0000, irq}, 16'h0001);
      bus(1, late_collision_pkg::irq_status_offset, 32'hf);
      @(posedge clk);
      chk("irq", {15'h0000, irq}, 16'h0000);
      bus(0, late_collision_pkg::irq_status_offset, 0);
      chk("status", rd[15:0], 16'h0000);
      finish_test();
   end
endmodule
